// File: verilog/dcc_regs.vh
`ifndef DCC_REGS_VH
`define DCC_REGS_VH

// ----------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------
`define DCC_FRAME_BITS     5'h18
`define DCC_CNT_SAT        5'h19
`define DCC_CHAN_HI        17
`define DCC_CHAN_LO        16
`define DCC_SEL_HI         15
`define DCC_SEL_LO         13
`define DCC_SEL_CHAN_CTRL  3'h2
`define DCC_SEL_SOFTWARE   3'h4

// ----------------------------------------------------------------
// Channel control fields
// ----------------------------------------------------------------
`define DCC_CTL_POWER      8
`define DCC_CTL_CLEAR      7
`define DCC_CTL_DRIVE      6
`define DCC_CTL_RSEL       5
`define DCC_CTL_BOOST      4
`define DCC_CTL_OVR        3
`define DCC_CTL_RANGE_HI   2
`define DCC_CTL_RANGE_LO   0
`define DCC_CTL_RESET      9'h000
`define DCC_RANGE_RSVD     3'h7

// ----------------------------------------------------------------
// Software command fields
// ----------------------------------------------------------------
`define DCC_SW_USER        12
`define DCC_SW_CODE_HI     11
`define DCC_SW_CODE_LO     0
`define DCC_CODE_RESET     12'h555
`define DCC_CODE_SERVICE   12'h195

// ----------------------------------------------------------------
// Watchdog timing
// ----------------------------------------------------------------
// Timeout lengths in core_clk cycles at 40 MHz: 5, 10, 100 and 200 ms
`define DCC_WD_CYC0        24'h03_0D40
`define DCC_WD_CYC1        24'h06_1A80
`define DCC_WD_CYC2        24'h3D_0900
`define DCC_WD_CYC3        24'h7A_1200
`define DCC_WD_ZERO        24'h00_0000
`define DCC_WD_ONE         24'h00_0001

`endif

// File: verilog/dcc_sync.v
`timescale 1ns/1ps

// Two-stage synchroniser for the pins from the serial link and the clear pin
module dcc_sync (
    input  wire       core_clk,
    input  wire       rst,
    input  wire [3:0] pin_in,
    output wire [3:0] pin_sync
);

    reg [3:0] stage1;
    reg [3:0] stage2;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_bit
            // Idle level is 1 so an open frame is not seen out of reset
            always @(posedge core_clk) begin
                if (rst) begin
                    stage1[g] <= 1'b1;
                    stage2[g] <= 1'b1;
                end else begin
                    stage1[g] <= pin_in[g];
                    stage2[g] <= stage1[g];
                end
            end
        end
    endgenerate

    assign pin_sync = stage2;

endmodule // dcc_sync

// File: verilog/dcc_top.v
// Function
// - Top bits 010 mark a channel control write; bits 12..9 ignored.
// - Power bit 8 powers converter, core and amplifiers of that channel only.
// - Bit 7 decides whether the channel follows the clear pin.
// - Bit 6 enables the channel output; zero by default.
// - Bit 5 picks internal sense resistor when 1, external when 0.
// - Bit 4 powers the channel boost converter up when 1.
// - A global input powers all boost converters up together.
// - Bit 3 adds overrange only on voltage ranges; default off.
// - Bits 2..0 choose one of seven output ranges; 000 default.
// - A software register write can reset the whole part. Here the synchroniser and serial shift register keep their state.
// - Software bit 12 is mirrored into the status user toggle bit.
// - Missed service with watchdog enabled raises the fault flag.
// - Disabled watchdog needs no service and raises no fault.
// - Code 0x555 in software bits 11..0 performs a software reset.
// - Period select 00,01,10,11 gives 5,10,100,200 ms timeout.
// - Watchdog runs only while its enable is 1; off after reset. The enable here is the watchdog_on input, which has no reset value.
`timescale 1ns/1ps
`include "dcc_regs.vh"

module dcc_top #(
    parameter [23:0] WD_CYC0 = `DCC_WD_CYC0,
    parameter [23:0] WD_CYC1 = `DCC_WD_CYC1,
    parameter [23:0] WD_CYC2 = `DCC_WD_CYC2,
    parameter [23:0] WD_CYC3 = `DCC_WD_CYC3
) (
    input  wire        core_clk,
    input  wire        rst,
    input  wire        sync_n,
    input  wire        sclk,
    input  wire        serial_in_line,
    input  wire        clear_pin,
    input  wire        all_boost_power_up,
    input  wire        watchdog_on,
    input  wire [1:0]  watchdog_period_select,
    output reg  [3:0]  chan_power_up,
    output reg  [3:0]  clear_participation,
    output reg  [3:0]  channel_cleared,
    output reg  [3:0]  output_drive_on,
    output reg  [3:0]  sense_resistor_select,
    output reg  [3:0]  boost_power,
    output reg  [3:0]  voltage_overrange,
    output reg  [11:0] output_range_code,
    output reg         user_toggle,
    output reg         soft_reset,
    output reg         fault_alert
);

    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    wire [3:0] pin_sync;
    wire       sync_n_s;
    wire       sclk_s;
    wire       serial_in_s;
    wire       clear_s;

    dcc_sync u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pin_in   ({clear_pin, serial_in_line, sclk, sync_n}),
        .pin_sync (pin_sync)
    );

    assign sync_n_s = pin_sync[0];
    assign sclk_s   = pin_sync[1];
    assign serial_in_s = pin_sync[2];
    assign clear_s  = pin_sync[3];

    // ----------------------------------------------------------------
    // Serial shift register
    // ----------------------------------------------------------------
    reg        sclk_d;
    reg        sync_d;
    reg [23:0] shift;
    reg [4:0]  bit_cnt;
    wire       sclk_rise;
    wire       frame_end;
    wire       frame_ok;

    // Edges are found on synchronised copies; the link clock is far
    // slower than core_clk, so no edge is missed
    assign sclk_rise = sclk_s & ~sclk_d;
    assign frame_end = sync_n_s & ~sync_d;
    // Only a frame of exactly the full length is acted on
    assign frame_ok  = frame_end & (bit_cnt == `DCC_FRAME_BITS);

    // Edge history of the link clock and the frame strobe
    always @(posedge core_clk) begin
        if (rst) begin
            sclk_d <= 1'b1;
            sync_d <= 1'b1;
        end else begin
            sclk_d <= sclk_s;
            sync_d <= sync_n_s;
        end
    end

    // Data shifts in MSB first on each rising link clock inside a frame
    always @(posedge core_clk) begin
        if (rst) begin
            shift   <= 24'h00_0000;
            bit_cnt <= 5'h00;
        end else if (sync_n_s) begin
            bit_cnt <= 5'h00;
        end else if (sclk_rise) begin
            shift <= {shift[22:0], serial_in_s};
            if (bit_cnt != `DCC_CNT_SAT) begin
                bit_cnt <= bit_cnt + 5'h01; // Saturates so long frames stay rejected
            end
        end
    end

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    wire [2:0]  reg_sel;
    wire [1:0]  chan_addr;
    wire [11:0] sw_code;
    wire        wr_ctrl;
    wire        wr_soft;
    wire        wd_service;
    wire        part_rst;

    assign reg_sel    = shift[`DCC_SEL_HI:`DCC_SEL_LO];
    assign chan_addr  = shift[`DCC_CHAN_HI:`DCC_CHAN_LO];
    assign sw_code    = shift[`DCC_SW_CODE_HI:`DCC_SW_CODE_LO];
    // Bits 12..9 are never looked at for a control write
    assign wr_ctrl    = frame_ok & (reg_sel == `DCC_SEL_CHAN_CTRL);
    assign wr_soft    = frame_ok & (reg_sel == `DCC_SEL_SOFTWARE);
    assign wd_service = wr_soft & (sw_code == `DCC_CODE_SERVICE);
    // Software reset acts one cycle after the frame, like a power-on reset
    assign part_rst   = rst | soft_reset;

    // Reset code gives a one-cycle pulse that clears the part except the synchroniser and serial shift register
    always @(posedge core_clk) begin
        if (part_rst) begin
            soft_reset <= 1'b0;
        end else begin
            soft_reset <= wr_soft & (sw_code == `DCC_CODE_RESET);
        end
    end

    // User bit mirrored for a loop-back check of the serial lines
    always @(posedge core_clk) begin
        if (part_rst) begin
            user_toggle <= 1'b0;
        end else if (wr_soft) begin
            user_toggle <= shift[`DCC_SW_USER];
        end
    end

    // ----------------------------------------------------------------
    // Per-channel control copies
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_chan
            reg  [8:0] ctl;
            wire       is_current;

            assign is_current = ctl[`DCC_CTL_RANGE_HI];

            // Only the addressed channel takes the write
            always @(posedge core_clk) begin
                if (part_rst) begin
                    ctl <= `DCC_CTL_RESET;
                end else if (wr_ctrl && (chan_addr == i)) begin
                    ctl[`DCC_CTL_POWER:`DCC_CTL_OVR] <= shift[`DCC_CTL_POWER:`DCC_CTL_OVR];
                    // A reserved code would drive an undefined range; hold the old one
                    if (shift[`DCC_CTL_RANGE_HI:`DCC_CTL_RANGE_LO] != `DCC_RANGE_RSVD) begin
                        ctl[`DCC_CTL_RANGE_HI:`DCC_CTL_RANGE_LO] <=
                            shift[`DCC_CTL_RANGE_HI:`DCC_CTL_RANGE_LO];
                    end
                end
            end

            // Registered outputs towards the analog channel
            always @(posedge core_clk) begin
                if (part_rst) begin
                    chan_power_up[i]         <= 1'b0;
                    clear_participation[i]   <= 1'b0;
                    channel_cleared[i]       <= 1'b0;
                    output_drive_on[i]       <= 1'b0;
                    sense_resistor_select[i] <= 1'b0;
                    boost_power[i]           <= 1'b0;
                    voltage_overrange[i]     <= 1'b0;
                    output_range_code[3*i+2:3*i] <= 3'h0;
                end else begin
                    chan_power_up[i]         <= ctl[`DCC_CTL_POWER];
                    clear_participation[i]   <= ctl[`DCC_CTL_CLEAR];
                    channel_cleared[i]       <= clear_s & ctl[`DCC_CTL_CLEAR];
                    output_drive_on[i]       <= ctl[`DCC_CTL_DRIVE];
                    sense_resistor_select[i] <= ctl[`DCC_CTL_RSEL];
                    // Converter stays up while the channel core or output still needs it
                    boost_power[i]           <= ctl[`DCC_CTL_BOOST] | all_boost_power_up
                                              | ctl[`DCC_CTL_POWER] | ctl[`DCC_CTL_DRIVE];
                    // Current ranges have no overrange
                    voltage_overrange[i]     <= ctl[`DCC_CTL_OVR] & ~is_current;
                    output_range_code[3*i+2:3*i] <=
                        ctl[`DCC_CTL_RANGE_HI:`DCC_CTL_RANGE_LO];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------
    reg  [23:0] wd_cnt;
    reg  [23:0] wd_limit;
    wire        wd_expire;

    // Timeout length picked from the period select
    always @* begin
        case (watchdog_period_select)
            2'b00:   wd_limit = WD_CYC0;
            2'b01:   wd_limit = WD_CYC1;
            2'b10:   wd_limit = WD_CYC2;
            default: wd_limit = WD_CYC3;
        endcase
    end

    // A service in the last cycle restarts the count, so no false expiry
    assign wd_expire = (wd_cnt >= (wd_limit - `DCC_WD_ONE)) & ~wd_service;

    // Counter and fault flag; a latched fault stays up until a service or until the watchdog is disabled,
    // and a service on the last count restarts the count instead of expiring
    always @(posedge core_clk) begin
        if (part_rst || !watchdog_on) begin
            wd_cnt      <= `DCC_WD_ZERO;
            fault_alert <= 1'b0;
        end else begin
            if (wd_service || wd_expire) begin
                wd_cnt <= `DCC_WD_ZERO;
            end else begin
                wd_cnt <= wd_cnt + `DCC_WD_ONE;
            end
            fault_alert <= wd_expire | (fault_alert & ~wd_service);
        end
    end

endmodule // dcc_top

// File: dv/dcc_top_sva.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker for channel control and software decode
// ------------------------------------------------------------
module dcc_top_sva #(
    parameter [23:0] WD_CYC0 = 24'h00_0014,
    parameter [23:0] WD_CYC1 = 24'h00_0028,
    parameter [23:0] WD_CYC2 = 24'h00_003C,
    parameter [23:0] WD_CYC3 = 24'h00_0050
) (
    input wire        core_clk,
    input wire        rst,
    input wire        sync_n,
    input wire        sclk,
    input wire        serial_in_line,
    input wire        clear_pin,
    input wire        all_boost_power_up,
    input wire        watchdog_on,
    input wire [1:0]  watchdog_period_select,
    input wire [3:0]  chan_power_up,
    input wire [3:0]  clear_participation,
    input wire [3:0]  channel_cleared,
    input wire [3:0]  output_drive_on,
    input wire [3:0]  sense_resistor_select,
    input wire [3:0]  boost_power,
    input wire [3:0]  voltage_overrange,
    input wire [11:0] output_range_code,
    input wire        user_toggle,
    input wire        soft_reset,
    input wire        fault_alert
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Top range bit of each channel marks a current range
    wire [3:0]  rng_hi = {output_range_code[11], output_range_code[8],
                          output_range_code[5], output_range_code[2]};
    wire [23:0] lim = watchdog_period_select[1] ?
                      (watchdog_period_select[0] ? WD_CYC3 : WD_CYC2) :
                      (watchdog_period_select[0] ? WD_CYC1 : WD_CYC0);
    int         on_cnt;
    int         quiet_cnt;
    // Enabled time bounds the time since restart from above; time with no
    // frame at all bounds it from below, since only a frame can service
    always @(posedge core_clk) begin
        on_cnt    <= (rst || soft_reset || !watchdog_on) ? 0 : on_cnt + 1;
        quiet_cnt <= (rst || soft_reset || !watchdog_on || !sync_n) ? 0 : quiet_cnt + 1;
    end
    sequence soft_clears;
        ##2 (chan_power_up == 4'h0 && output_drive_on == 4'h0 && user_toggle == 1'b0);
    endsequence
    rst_quiet_a: assert property ($fell(rst) |-> chan_power_up == 4'h0 &&
        output_drive_on == 4'h0 && sense_resistor_select == 4'h0 && boost_power == 4'h0
        && voltage_overrange == 4'h0 && output_range_code == 12'h000 && !fault_alert)
        else $error("outputs not at defaults after reset");
    soft_pulse_a: assert property (soft_reset |=> !soft_reset)
        else $error("soft reset longer than one cycle");
    soft_clear_a: assert property (soft_reset |-> soft_clears)
        else $error("soft reset did not clear state");
    ovr_volt_a: assert property ((voltage_overrange & rng_hi) == 4'h0)
        else $error("overrange on a current range");
    rng_rsvd_a: assert property (output_range_code[2:0] != 3'h7 &&
        output_range_code[5:3] != 3'h7 && output_range_code[8:6] != 3'h7 &&
        output_range_code[11:9] != 3'h7) else $error("reserved range applied");
    clr_follow_a: assert property ((channel_cleared & ~clear_participation) == 4'h0)
        else $error("channel cleared without participation");
    boost_keep_a: assert property (((chan_power_up | output_drive_on) & ~boost_power) == 4'h0)
        else $error("boost off while power or drive set");
    all_boost_a: assert property (all_boost_power_up [*2] |=> boost_power == 4'hf)
        else $error("global boost power-up ignored");
    wd_off_a: assert property (!watchdog_on |=> !fault_alert)
        else $error("fault with watchdog off");
    wd_early_a: assert property ($rose(fault_alert) |-> on_cnt + 2 >= lim)
        else $error("watchdog fault too early");
    wd_late_a: assert property (quiet_cnt > lim + 8 |-> fault_alert)
        else $error("watchdog fault missing");
endmodule // dcc_top_sva

bind dcc_top dcc_top_sva #(.WD_CYC0(WD_CYC0), .WD_CYC1(WD_CYC1), .WD_CYC2(WD_CYC2),
    .WD_CYC3(WD_CYC3)) u_sva (.core_clk, .rst, .sync_n, .sclk, .serial_in_line,
    .clear_pin, .all_boost_power_up, .watchdog_on, .watchdog_period_select,
    .chan_power_up, .clear_participation, .channel_cleared, .output_drive_on,
    .sense_resistor_select, .boost_power, .voltage_overrange, .output_range_code,
    .user_toggle, .soft_reset, .fault_alert);

// File: dv/dcc_host.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host serial controller model
// ------------------------------------------------------------
module dcc_host (
    input  wire  core_clk,
    output logic sync_n,
    output logic sclk,
    output logic serial_in_line
);
    // Link clock stands low outside frames
    initial begin
        sync_n = 1'b1;
        sclk = 1'b0;
        serial_in_line = 1'b1;
    end
    // One frame, MSB first; each link clock phase lasts 4 core cycles
    task automatic send(input logic [23:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge core_clk) #1;
            {sync_n, sclk, serial_in_line} = {2'b00, w[i]};
            repeat (4) @(posedge core_clk);
            #1 sclk = 1'b1;
            repeat (3) @(posedge core_clk);
        end
        // Released data line shows the inverse of its last bit, not a stale value
        @(posedge core_clk) #1;
        {sclk, serial_in_line} = {1'b0, ~serial_in_line};
        repeat (4) @(posedge core_clk);
        #1 sync_n = 1'b1;
        repeat (4) @(posedge core_clk);
    endtask
endmodule // dcc_host

// File: dv/dcc_top_tb.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Bench for channel control and software decode
// ------------------------------------------------------------
module dcc_top_tb;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        clear_pin = 1'b0;
    logic        all_boost_power_up = 1'b0;
    logic        watchdog_on = 1'b0;
    logic [1:0]  watchdog_period_select = 2'b00;
    wire         sync_n, sclk, serial_in_line, user_toggle, soft_reset, fault_alert;
    wire  [3:0]  chan_power_up, clear_participation, channel_cleared, output_drive_on;
    wire  [3:0]  sense_resistor_select, boost_power, voltage_overrange;
    wire  [11:0] output_range_code;
    int          miscompares = 0;
    int          check_count = 0;
    int          pulses = 0;
    int          k;
    always #12.5 core_clk = ~core_clk;
    dcc_host u_host (.core_clk, .sync_n, .sclk, .serial_in_line);
    // Short watchdog periods keep the run brief
    dcc_top #(.WD_CYC0(24'h00_012C), .WD_CYC1(24'h00_0190), .WD_CYC2(24'h00_01F4),
        .WD_CYC3(24'h00_0258)) DUT (.core_clk, .rst, .sync_n, .sclk, .serial_in_line,
        .clear_pin, .all_boost_power_up, .watchdog_on, .watchdog_period_select,
        .chan_power_up, .clear_participation, .channel_cleared, .output_drive_on,
        .sense_resistor_select, .boost_power, .voltage_overrange, .output_range_code,
        .user_toggle, .soft_reset, .fault_alert);
    // Soft reset pulses seen
    always @(posedge core_clk) if (soft_reset === 1'b1) pulses++;
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Frame then settle; outputs land 4 core edges after the strobe rises
    task automatic wr(input logic [23:0] w, input int n = 24);
        u_host.send(w, n);
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    // Don't-care bits 12..9 are always sent as ones
    function automatic logic [23:0] ctl(input logic [1:0] ch, input logic [8:0] f);
        return {6'h00, ch, 3'b010, 4'hf, f};
    endfunction
    function automatic logic [23:0] sw(input logic u, input logic [11:0] c);
        return {8'h00, 3'b100, u, c};
    endfunction
    task automatic conclude();
        $display("checks=%0d miscompares=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (100000) @(posedge core_clk);
        miscompares++;
        conclude();
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge core_clk);
        #1 rst = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        chk({chan_power_up, output_drive_on, sense_resistor_select}, 12'h000);
        chk({clear_participation, boost_power, voltage_overrange}, 12'h000);
        chk(output_range_code, 12'h000);
        wr(ctl(2'd1, 9'h100));
        chk({chan_power_up, output_drive_on, boost_power}, 12'h202);
        repeat (8001) @(posedge core_clk);
        wr(ctl(2'd1, 9'h1FB));
        chk({clear_participation, output_drive_on, sense_resistor_select}, 12'h222);
        chk({voltage_overrange, boost_power, chan_power_up}, 12'h222);
        wr(ctl(2'd2, 9'h00C));
        chk({voltage_overrange, output_range_code[11:4]}, 12'h211);
        $display("test fields done");
        for (k = 0; k < 8; k++) begin
            wr(ctl(2'd0, {6'h00, k[2:0]}));
            chk(output_range_code, {9'h023, (k < 7) ? k[2:0] : 3'h6});
        end
        wr(24'h00_7FFF);
        wr(ctl(2'd0, 9'h1F8), 23);
        chk({chan_power_up, output_range_code[7:0]}, 12'h21E);
        clear_pin = 1'b1;
        repeat (5) @(posedge core_clk);
        #1 chk(channel_cleared, 4'h2);
        all_boost_power_up = 1'b1;
        repeat (3) @(posedge core_clk);
        #1 chk(boost_power, 4'hf);
        {clear_pin, all_boost_power_up} = 2'b00;
        wr(ctl(2'd1, 9'h000));
        chk({boost_power, channel_cleared}, 8'h00);
        $display("test ranges done");
        wr(sw(1'b1, 12'h000));
        chk(user_toggle, 1'b1);
        wr(sw(1'b0, 12'h000));
        chk(user_toggle, 1'b0);
        for (k = 0; k < 4; k++) begin
            {watchdog_on, watchdog_period_select} = {1'b1, k[1:0]};
            repeat (296 + 100 * k) @(posedge core_clk);
            #1 chk(fault_alert, 1'b0);
            repeat (8) @(posedge core_clk);
            #1 chk(fault_alert, 1'b1);
            watchdog_on = 1'b0;
            repeat (2) @(posedge core_clk);
            #1 chk(fault_alert, 1'b0);
        end
        {watchdog_on, watchdog_period_select} = 3'b100;
        repeat (3) wr(sw(1'b1, 12'h195));
        chk(fault_alert, 1'b0);
        repeat (310) @(posedge core_clk);
        #1 chk(fault_alert, 1'b1);
        wr(sw(1'b1, 12'h195));
        chk(fault_alert, 1'b0);
        watchdog_on = 1'b0;
        repeat (700) @(posedge core_clk);
        #1 chk(fault_alert, 1'b0);
        $display("test watchdog done");
        wr(ctl(2'd3, 9'h1FF));
        chk(pulses, 12'h000);
        // User bit sent as one so the check below proves the reset cleared it
        wr(sw(1'b1, 12'h555));
        chk(pulses, 12'h001);
        chk({user_toggle, chan_power_up, output_drive_on}, 12'h000);
        chk(output_range_code, 12'h000);
        $display("test soft reset done");
        conclude();
    end
endmodule // dcc_top_tb
